// ==== inc/uirq_pkg.sv ====
// Constants and types for the UART interrupt logic.
// Assumes a host register port with one-cycle strobes and read data one cycle later.
package uirq_pkg;
  // ==========================================================================
  // Register map
  localparam logic [2:0] UIRQ_OFS_IEM   = 3'h1;
  localparam logic [2:0] UIRQ_OFS_ISS   = 3'h2;
  localparam logic [2:0] UIRQ_OFS_LSR   = 3'h5;
  localparam logic [2:0] UIRQ_OFS_MSR   = 3'h6;
  localparam logic [2:0] UIRQ_OFS_CTL   = 3'h7;
  localparam logic [7:0] UIRQ_IEM_RST   = 8'h00;
  localparam logic [7:0] UIRQ_IEM_LOW   = 8'h0f;
  localparam logic [7:0] UIRQ_CTL_RST   = 8'h00;
  // Control register fields.
  localparam int UIRQ_CTL_FIFO = 0;
  localparam int UIRQ_CTL_ENH  = 1;
  localparam int UIRQ_CTL_IMM  = 2;
  localparam int UIRQ_CTL_ACTS = 3;
  localparam int UIRQ_CTL_ARTS = 4;
  localparam int UIRQ_CTL_HDX  = 5;
  // Enable mask fields.
  localparam int UIRQ_IE_RX   = 0;
  localparam int UIRQ_IE_TX   = 1;
  localparam int UIRQ_IE_LS   = 2;
  localparam int UIRQ_IE_MS   = 3;
  localparam int UIRQ_IE_XOFF = 5;
  localparam int UIRQ_IE_RTS  = 6;
  localparam int UIRQ_IE_CTS  = 7;
  // ==========================================================================
  // Status codes, bits 5:0
  localparam logic [5:0] UIRQ_CODE_LS   = 6'h06;
  localparam logic [5:0] UIRQ_CODE_TO   = 6'h0c;
  localparam logic [5:0] UIRQ_CODE_RX   = 6'h04;
  localparam logic [5:0] UIRQ_CODE_TX   = 6'h02;
  localparam logic [5:0] UIRQ_CODE_MS   = 6'h00;
  localparam logic [5:0] UIRQ_CODE_XOFF = 6'h10;
  localparam logic [5:0] UIRQ_CODE_FLOW = 6'h20;
  localparam logic [5:0] UIRQ_CODE_NONE = 6'h01;
  // ==========================================================================
  // Timeout: four characters plus twelve bits, counted in bit ticks
  localparam int         UIRQ_TO_CHARS = 4;
  localparam int         UIRQ_TO_BITS  = 12;
  localparam int         UIRQ_BITS_PER_CHAR = 10;
  localparam logic [7:0] UIRQ_TO_TICKS =
    8'(UIRQ_TO_CHARS * UIRQ_BITS_PER_CHAR + UIRQ_TO_BITS);
  // Sources in priority order.
  typedef enum logic [2:0] {
    UIRQ_S_LS = 3'b000, UIRQ_S_TO = 3'b001, UIRQ_S_RX = 3'b010, UIRQ_S_TX = 3'b011,
    UIRQ_S_MS = 3'b100, UIRQ_S_XOFF = 3'b101, UIRQ_S_FLOW = 3'b110, UIRQ_S_NONE = 3'b111
  } uirq_src_e;
endpackage

// ==== inc/uirq_pend_if.sv ====
// Interface carrying pending-source flags to the prioritiser.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface uirq_pend_if;
  logic [6:0] pend;
  logic [5:0] code;
  logic       any;
  modport src (output pend, input code, input any);
  modport pri (input pend, output code, output any);
endinterface
`default_nettype wire

// ==== logic/uirq_prio.sv ====
// Fixed-priority encoder for the interrupt status code.
// Assumes pend bit 0 is the highest-priority source.
`timescale 1ns/1ps
`default_nettype none
module uirq_prio
  import uirq_pkg::*;
(
  uirq_pend_if.pri p
);
  always_comb begin
    p.any  = |p.pend;
    p.code = UIRQ_CODE_NONE;
    // Lowest priority first so the highest pending source overrides.
    if (p.pend[6]) p.code = UIRQ_CODE_FLOW; // [RULE_17]
    if (p.pend[5]) p.code = UIRQ_CODE_XOFF;
    if (p.pend[4]) p.code = UIRQ_CODE_MS;
    if (p.pend[3]) p.code = UIRQ_CODE_TX;
    if (p.pend[2]) p.code = UIRQ_CODE_RX;
    if (p.pend[1]) p.code = UIRQ_CODE_TO;
    if (p.pend[0]) p.code = UIRQ_CODE_LS;   // [RULE_18]
  end
endmodule
`default_nettype wire

// ==== logic/uirq_top.sv ====
// Interrupt enable, priority, status and clear logic for one UART channel.
// Assumes receiver, transmitter and flow engines give single-cycle events and levels.
// Notes on behaviour
// RULE_01: FIFO receive interrupt follows trigger level.
// RULE_02: Data-ready bit set on push, cleared empty.
// RULE_03: Enables 0-3 clear gives polled mode.
// RULE_04: Line status reports overrun, errors, transmitter state.
// RULE_05: Enable bit 0 gates receive-data interrupt.
// RULE_06: Enable bit 1 gates transmit-ready, fires immediately.
// RULE_07: Overrun immediate; other errors at read-out.
// RULE_08: Enable bit 3 gates modem status interrupt.
// RULE_09: Enable bits 4,5 writable only when enhanced.
// RULE_10: Bits 6,7 enable RTS, CTS rising interrupts.
// RULE_11: Timeout after four chars plus twelve bits.
// RULE_12: Transmit-ready from trigger, or empty in half-duplex.
// RULE_13: Status reads clear line, modem, timeout sources; timeout clears on a receive data pop or empty FIFO instead.
// RULE_14: Status read or holding write clears transmit-ready.
// RULE_15: Xoff clears on Xon; special on next char.
// RULE_16: Modem status read clears flow-change interrupts.
// RULE_17: Status code per priority level table.
// RULE_18: Status read shows highest pending, others queued.
// RULE_19: Status bit 0 low while interrupt pending.
// RULE_20: Status bit 4 needs enhanced and Xoff enable.
// RULE_21: Status bit 5 only with enhanced functions.
// RULE_22: Flow-change interrupts only in automatic flow control.
// RULE_23: Status bits 7:6 mirror FIFO enable.
// RULE_24: Interrupt output high while any source pending.
//
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module uirq_top
  import uirq_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output var  logic [7:0] o_rdata,
  output var  logic       o_irq,
  input  wire logic       i_rx_push,
  input  wire logic       i_rx_empty,
  input  wire logic       i_rx_at_trig,
  input  wire logic       i_rx_pop,
  input  wire logic       i_rx_overrun,
  input  wire logic [2:0] i_rx_err_push,
  input  wire logic [2:0] i_rx_err_head,
  input  wire logic       i_rx_err_any,
  input  wire logic       i_bit_tick,
  input  wire logic       i_tx_hold_empty,
  input  wire logic       i_tx_below_trig,
  input  wire logic       i_tx_all_empty,
  input  wire logic       i_tx_hold_wr,
  input  wire logic [3:0] i_modem_delta,
  input  wire logic       i_xoff_match,
  input  wire logic       i_xon_match,
  input  wire logic       i_special_match,
  input  wire logic       i_rts_level,
  input  wire logic       i_cts_level
);
  import uirq_pkg::*;

  // ==========================================================================
  // State
  logic [7:0] iem_q, iem_d;
  logic [7:0] ctl_q, ctl_d;
  logic [7:0] rdata_q, rdata_d;
  logic       irq_q, irq_d;
  logic       ovr_q, ovr_d;
  logic [2:0] err_q, err_d;
  logic       ls_q, ls_d;
  logic       to_q, to_d;
  logic [7:0] to_cnt_q, to_cnt_d;
  logic       tx_q, tx_d;
  logic [3:0] ms_q, ms_d;
  logic       xoff_q, xoff_d;
  logic       spec_q, spec_d;
  logic       flow_q, flow_d;
  logic       rts_q, rts_d;
  logic       cts_q, cts_d;
  logic       txe_q, txe_d;

  uirq_pend_if pif ();

  uirq_prio u_prio (
    .p (pif.pri)
  );

  function automatic logic hit(input logic [2:0] a, input logic [2:0] ofs, input logic s);
    hit = s && (a == ofs);
  endfunction

  logic rd_iss, rd_lsr, rd_msr, rd_rhr;
  logic fifo_en, enh, rx_lvl, tx_src;
  logic [7:0] lsr_val, iss_val;

  // ==========================================================================
  // Source conditions
  always_comb begin
    fifo_en = ctl_q[UIRQ_CTL_FIFO];
    enh     = ctl_q[UIRQ_CTL_ENH];
    rd_iss  = hit(i_addr, UIRQ_OFS_ISS, i_rd);
    rd_lsr  = hit(i_addr, UIRQ_OFS_LSR, i_rd);
    rd_msr  = hit(i_addr, UIRQ_OFS_MSR, i_rd);
    rd_rhr  = i_rx_pop;
    // Non-FIFO mode: any held character; FIFO mode: trigger level.
    rx_lvl  = fifo_en ? i_rx_at_trig : !i_rx_empty; // [RULE_01] [RULE_05]
    if (ctl_q[UIRQ_CTL_HDX]) begin
      tx_src = i_tx_all_empty; // [RULE_12]
    end else begin
      tx_src = fifo_en ? (i_tx_below_trig || i_tx_hold_empty) : i_tx_hold_empty;
    end
    // [RULE_02] [RULE_04]
    lsr_val = {i_rx_err_any, i_tx_all_empty, i_tx_hold_empty, err_q, ovr_q, !i_rx_empty};
    pif.pend[0] = iem_q[UIRQ_IE_LS] && ls_q;
    pif.pend[1] = iem_q[UIRQ_IE_RX] && to_q;
    pif.pend[2] = iem_q[UIRQ_IE_RX] && rx_lvl;
    pif.pend[3] = iem_q[UIRQ_IE_TX] && tx_q;           // [RULE_06]
    pif.pend[4] = iem_q[UIRQ_IE_MS] && (|ms_q);         // [RULE_08]
    pif.pend[5] = enh && iem_q[UIRQ_IE_XOFF] && (xoff_q || spec_q); // [RULE_20]
    pif.pend[6] = enh && flow_q;                        // [RULE_21]
  end

  // The status byte waits on the prioritiser, so it sits apart from the pending flags.
  always_comb begin
    // [RULE_23] [RULE_19]
    iss_val = {fifo_en, fifo_en, pif.code};
  end

  // ==========================================================================
  // Register file and sticky sources
  always_comb begin
    iem_d    = iem_q;
    ctl_d    = ctl_q;
    rdata_d  = 8'h00;
    ovr_d    = ovr_q;
    err_d    = err_q;
    ls_d     = ls_q;
    to_d     = to_q;
    to_cnt_d = to_cnt_q;
    tx_d     = tx_q;
    ms_d     = ms_q;
    xoff_d   = xoff_q;
    spec_d   = spec_q;
    flow_d   = flow_q;
    rts_d    = i_rts_level;
    cts_d    = i_cts_level;
    txe_d    = tx_src;
    if (hit(i_addr, UIRQ_OFS_IEM, i_wr)) begin
      // Upper enables stay put unless enhanced functions are on.
      iem_d = enh ? i_wdata : ((iem_q & ~UIRQ_IEM_LOW) | (i_wdata & UIRQ_IEM_LOW)); // [RULE_09]
    end
    if (hit(i_addr, UIRQ_OFS_CTL, i_wr)) begin
      ctl_d = i_wdata;
    end
    // Clears first, so same-cycle events below win.
    if (rd_lsr) begin
      ovr_d = 1'b0;
      err_d = 3'h0;
      ls_d  = 1'b0; // [RULE_13]
    end
    if (rd_msr) begin
      ms_d   = 4'h0;
      flow_d = 1'b0; // [RULE_16]
    end
    if (rd_iss || i_tx_hold_wr) begin
      tx_d = 1'b0; // [RULE_14]
    end
    if (rd_iss || i_xon_match) begin
      xoff_d = 1'b0; // [RULE_15]
    end
    if (rd_iss || i_rx_push) begin
      spec_d = 1'b0; // [RULE_15]
    end
    if (rd_rhr || i_rx_empty) begin
      to_d     = 1'b0;
      to_cnt_d = 8'h00;
    end else if (i_rx_push) begin
      to_cnt_d = 8'h00;
    end else if (i_bit_tick && !to_q) begin
      if (to_cnt_q == UIRQ_TO_TICKS - 8'h01) begin
        to_d = 1'b1; // [RULE_11]
      end else begin
        to_cnt_d = to_cnt_q + 8'h01;
      end
    end
    if (i_rx_overrun) begin
      ovr_d = 1'b1;
      ls_d  = 1'b1; // [RULE_07]
    end
    if (ctl_q[UIRQ_CTL_IMM] && i_rx_push && (|i_rx_err_push)) begin
      err_d = err_q | i_rx_err_push;
      ls_d  = 1'b1; // [RULE_07]
    end
    if (!ctl_q[UIRQ_CTL_IMM] && rd_rhr && (|i_rx_err_head)) begin
      err_d = err_q | i_rx_err_head;
      ls_d  = 1'b1; // [RULE_07]
    end
    // Rising source, or enabling while already empty, raises transmit-ready.
    if ((tx_src && !txe_q) ||
        (tx_src && hit(i_addr, UIRQ_OFS_IEM, i_wr) && i_wdata[UIRQ_IE_TX] &&
         !iem_q[UIRQ_IE_TX])) begin
      tx_d = 1'b1; // [RULE_06]
    end
    ms_d = ms_d | i_modem_delta;
    if (i_xoff_match) xoff_d = 1'b1;
    if (i_special_match) spec_d = 1'b1;
    if ((ctl_q[UIRQ_CTL_ARTS] && iem_q[UIRQ_IE_RTS] && i_rts_level && !rts_q) ||
        (ctl_q[UIRQ_CTL_ACTS] && iem_q[UIRQ_IE_CTS] && i_cts_level && !cts_q)) begin
      flow_d = 1'b1; // [RULE_10] [RULE_22]
    end
    if (i_rd) begin
      case (i_addr)
        UIRQ_OFS_IEM: rdata_d = iem_q;
        UIRQ_OFS_ISS: rdata_d = iss_val; // [RULE_18]
        UIRQ_OFS_LSR: rdata_d = lsr_val; // [RULE_03]
        UIRQ_OFS_MSR: rdata_d = {2'h0, flow_q, 1'b0, ms_q};
        UIRQ_OFS_CTL: rdata_d = ctl_q;
        default:      rdata_d = 8'h00;
      endcase
    end
    irq_d = pif.any; // [RULE_24]
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      iem_q    <= UIRQ_IEM_RST;
      ctl_q    <= UIRQ_CTL_RST;
      rdata_q  <= 8'h00;
      irq_q    <= 1'b0;
      ovr_q    <= 1'b0;
      err_q    <= 3'h0;
      ls_q     <= 1'b0;
      to_q     <= 1'b0;
      to_cnt_q <= 8'h00;
      tx_q     <= 1'b0;
      ms_q     <= 4'h0;
      xoff_q   <= 1'b0;
      spec_q   <= 1'b0;
      flow_q   <= 1'b0;
      rts_q    <= 1'b0;
      cts_q    <= 1'b0;
      txe_q    <= 1'b0;
    end else begin
      iem_q    <= iem_d;
      ctl_q    <= ctl_d;
      rdata_q  <= rdata_d;
      irq_q    <= irq_d;
      ovr_q    <= ovr_d;
      err_q    <= err_d;
      ls_q     <= ls_d;
      to_q     <= to_d;
      to_cnt_q <= to_cnt_d;
      tx_q     <= tx_d;
      ms_q     <= ms_d;
      xoff_q   <= xoff_d;
      spec_q   <= spec_d;
      flow_q   <= flow_d;
      rts_q    <= rts_d;
      cts_q    <= cts_d;
      txe_q    <= txe_d;
    end
  end

  assign o_rdata = rdata_q;
  assign o_irq   = irq_q;

  // ==========================================================================
  // Checks
  a_irq_follows: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_24]
    o_irq == $past(pif.any)) else $error("irq does not follow pending");
  a_none_code: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_19]
    !pif.any |-> pif.code == UIRQ_CODE_NONE) else $error("idle code wrong");
  a_ls_first: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_18]
    pif.pend[0] |-> pif.code == UIRQ_CODE_LS) else $error("line status not first");
  a_to_code: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_17]
    pif.pend[1] && !pif.pend[0] |-> pif.code == UIRQ_CODE_TO) else $error("timeout code");
  a_tx_clear: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_14]
    i_tx_hold_wr && !tx_src |=> !tx_q) else $error("tx ready not cleared");
  a_ms_clear: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_13]
    rd_msr && i_modem_delta == 4'h0 |=> ms_q == 4'h0) else $error("modem not cleared");
  a_ovr_set: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_07]
    i_rx_overrun |=> ls_q && ovr_q) else $error("overrun not flagged");
  a_upper_lock: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_09]
    !enh |=> iem_q[7:4] == $past(iem_q[7:4])) else $error("upper enables changed");
  a_fifo_bits: assert property (@(posedge i_clk) disable iff (i_rst) // [RULE_23]
    rd_iss |=> o_rdata[7:6] == {2{$past(fifo_en)}}) else $error("fifo bits wrong");
  a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
endmodule
`default_nettype wire

// ==== bench/uirq_host.sv ====
// Host processor model that owns the register port of the interrupt logic.
// Assumes one clock; every strobe is one cycle and read data stand one cycle later.
`timescale 1ns/1ps
`default_nettype none
module uirq_host (
  input  wire logic       i_clk,
  input  wire logic [7:0] i_rdata,
  output var  logic [2:0] o_addr,
  output var  logic [7:0] o_wdata,
  output var  logic       o_wr,
  output var  logic       o_rd
);
  initial begin
    o_addr = 3'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  // ==========================================================================
  // Bus cycles
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
    o_wdata <= ~d;
  endtask
  // Data are taken at the edge that closes the answer cycle.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd <= 1'b0;
    @(posedge i_clk);
    d = i_rdata;
  endtask
endmodule
`default_nettype wire

// ==== bench/tb_top.sv ====
// Self-checking bench for the UART interrupt logic.
// Assumes the host model drives the register port; the bench plays the UART datapath.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uirq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, d, r;
  logic wr, rd, irq;
  logic rx_empty = 1'b1, at_trig = 1'b0, err_any = 1'b0, hold_empty = 1'b0;
  logic below = 1'b0, all_empty = 1'b0, rts = 1'b0, cts = 1'b0, fifo = 1'b0;
  logic [11:0] ev = 12'h000;
  logic [2:0] err_push = 3'h0, err_head = 3'h0;
  bit [6:0] pend = 7'h00;
  logic [5:0] codes [7] = '{UIRQ_CODE_LS, UIRQ_CODE_TO, UIRQ_CODE_RX, UIRQ_CODE_TX,
                            UIRQ_CODE_MS, UIRQ_CODE_XOFF, UIRQ_CODE_FLOW};
  int mismatches = 0;
  int check_count = 0;
  always #20 clk = ~clk;
  uirq_host h (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
               .o_wr(wr), .o_rd(rd));
  uirq_top i_dut (.i_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .o_irq(irq), .i_rx_push(ev[0]), .i_rx_empty(rx_empty),
    .i_rx_at_trig(at_trig), .i_rx_pop(ev[1]), .i_rx_overrun(ev[2]), .i_rx_err_push(err_push),
    .i_rx_err_head(err_head), .i_rx_err_any(err_any), .i_bit_tick(ev[3]),
    .i_tx_hold_empty(hold_empty), .i_tx_below_trig(below), .i_tx_all_empty(all_empty),
    .i_tx_hold_wr(ev[7]), .i_modem_delta(ev[11:8]), .i_xoff_match(ev[4]),
    .i_xon_match(ev[5]), .i_special_match(ev[6]), .i_rts_level(rts), .i_cts_level(cts));
  // ==========================================================================
  // Reference model and checks
  function automatic logic [7:0] exp_iss();
    logic [5:0] code;
    code = UIRQ_CODE_NONE;
    for (int i = 6; i >= 0; i--) begin
      if (pend[i]) begin
        code = codes[i];
      end
    end
    return {fifo, fifo, code};
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // Checks the request line, then the status read, which drops transmit and Xoff.
  task automatic look();
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, {7'h00, |pend});
    h.rd(UIRQ_OFS_ISS, d);
    chk(d, exp_iss());
    pend[3] = 1'b0;
    pend[5] = 1'b0;
  endtask
  task automatic pulse(input logic [11:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 12'h000;
  endtask
  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    mismatches++;
    wrap_up();
  end
  // ==========================================================================
  // Scenarios
  initial begin
    void'($urandom(32'h1b73));
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    look();
    h.rd(UIRQ_OFS_IEM, d);
    chk(d, UIRQ_IEM_RST);
    h.rd(3'h0, d);
    chk(d, 8'h00);
    r = 8'($urandom);
    h.wr(UIRQ_OFS_IEM, r);
    h.rd(UIRQ_OFS_IEM, d);
    chk(d, r & UIRQ_IEM_LOW);
    h.wr(UIRQ_OFS_IEM, 8'h00);
    h.wr(UIRQ_OFS_CTL, 8'h01);
    fifo = 1'b1;
    err_any <= 1'($urandom);
    all_empty <= 1'($urandom);
    pulse(12'h001);
    rx_empty <= 1'b0;
    at_trig <= 1'b1;
    look();
    h.rd(UIRQ_OFS_LSR, d);
    chk(d, {err_any, all_empty, hold_empty, 5'h01});
    h.wr(UIRQ_OFS_IEM, 8'h05);
    pend[2] = 1'b1;
    look();
    pulse(12'h004);
    pend[0] = 1'b1;
    look();
    h.rd(UIRQ_OFS_LSR, d);
    chk(d & 8'h1e, 8'h02);
    pend[0] = 1'b0;
    look();
    err_head <= 3'h4;
    pulse(12'h002);
    err_head <= 3'h0;
    pend[0] = 1'b1;
    look();
    h.rd(UIRQ_OFS_LSR, d);
    chk(d & 8'h1e, 8'h10);
    h.wr(UIRQ_OFS_CTL, 8'h05);
    err_push <= 3'h1;
    pulse(12'h001);
    err_push <= 3'h0;
    look();
    h.rd(UIRQ_OFS_LSR, d);
    chk(d & 8'h1e, 8'h04);
    pend[0] = 1'b0;
    at_trig <= 1'b0;
    pend[2] = 1'b0;
    look();
    pulse(12'h001);
    repeat (51) pulse(12'h008);
    look();
    pulse(12'h008);
    pend[1] = 1'b1;
    look();
    pulse(12'h002);
    pend[1] = 1'b0;
    look();
    hold_empty <= 1'b1;
    h.wr(UIRQ_OFS_IEM, 8'h02);
    pend[3] = 1'b1;
    look();
    look();
    hold_empty <= 1'b0;
    repeat (2) @(posedge clk);
    hold_empty <= 1'b1;
    below <= 1'b1;
    pend[3] = 1'b1;
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    pulse(12'h080);
    pend[3] = 1'b0;
    look();
    all_empty <= 1'b0;
    h.wr(UIRQ_OFS_CTL, 8'h21);
    look();
    all_empty <= 1'b1;
    pend[3] = 1'b1;
    look();
    h.wr(UIRQ_OFS_IEM, 8'h08);
    r = 8'(4'h1 << ($urandom % 4));
    pulse({r[3:0], 8'h00});
    pend[4] = 1'b1;
    look();
    h.rd(UIRQ_OFS_MSR, d);
    chk({4'h0, d[3:0]}, r);
    pend[4] = 1'b0;
    look();
    h.wr(UIRQ_OFS_CTL, 8'h13);
    h.wr(UIRQ_OFS_IEM, 8'h60);
    pulse(12'h010);
    repeat (3) @(posedge clk);
    chk({7'h00, irq}, 8'h01);
    pulse(12'h020);
    look();
    pulse(12'h040);
    pend[5] = 1'b1;
    look();
    look();
    rts <= 1'b1;
    pend[6] = 1'b1;
    look();
    h.rd(UIRQ_OFS_MSR, d);
    chk(d & 8'h20, 8'h20);
    pend[6] = 1'b0;
    look();
    h.wr(UIRQ_OFS_IEM, 8'h80);
    cts <= 1'b1;
    look();
    h.wr(UIRQ_OFS_CTL, 8'h0b);
    cts <= 1'b0;
    repeat (2) @(posedge clk);
    cts <= 1'b1;
    pend[6] = 1'b1;
    look();
    h.rd(UIRQ_OFS_MSR, d);
    chk(d & 8'h20, 8'h20);
    pend[6] = 1'b0;
    look();
    h.wr(UIRQ_OFS_CTL, 8'h00);
    h.wr(UIRQ_OFS_IEM, 8'h01);
    fifo = 1'b0;
    pend[2] = 1'b1;
    look();
    wrap_up();
  end
endmodule
`default_nettype wire
